// ---- hw/asc_baud.v ----
// Bit timer for one channel: counts operation-clock ticks of one bit time.
// Assumes mck_tick is a one-cycle strobe from the shared prescaler.
`timescale 1ns/100ps
`default_nettype none
module asc_baud
(
  input  wire       clk,      // System clock.
  input  wire       rstn,     // Synchronous reset, active low.
  input  wire       restart,  // Restart the bit timer at zero.
  input  wire       mck_tick, // Operation clock tick.
  input  wire [6:0] div,      // Divisor field; bit time is 2*(div+1) ticks.
  output reg        half_tick,// Middle of a bit.
  output reg        bit_tick  // End of a bit.
);
  reg  [7:0] cnt_q;
  wire [7:0] last = {div, 1'b1};

  // Divisor below two is not supported by software; no clamp is spent on it.
  always @(posedge clk)
  begin
    if (!rstn || restart)
    begin
      cnt_q     <= 8'h00;
      half_tick <= 1'b0;
      bit_tick  <= 1'b0;
    end
    else
    begin
      half_tick <= mck_tick && (cnt_q == {1'b0, div});
      bit_tick  <= mck_tick && (cnt_q == last);
      if (mck_tick)
        cnt_q <= (cnt_q == last) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule // asc_baud
`default_nettype wire

// ---- hw/asc_defs.vh ----
// Constants for the serial channel pair: register offsets, fields, resets.
// Assumes a 32-bit AHB-Lite register window of 16 words.
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH
`define ASC_OFF_PEN      6'h00
`define ASC_OFF_PRESCALE 6'h04
`define ASC_OFF_TXMODE   6'h08
`define ASC_OFF_RXMODE   6'h0C
`define ASC_OFF_FORMAT   6'h10
`define ASC_OFF_TXSDR    6'h14
`define ASC_OFF_RXSDR    6'h18
`define ASC_OFF_STATUS   6'h1C
`define ASC_OFF_FLAGCLR  6'h20
`define ASC_MODE_MD      0
`define ASC_MODE_EN      7
`define ASC_FMT_INV      0
`define ASC_FMT_PAR_LO   1
`define ASC_FMT_PAR_HI   2
`define ASC_PAR_NONE     2'h0
`define ASC_PAR_ZERO     2'h1
`define ASC_PAR_EVEN     2'h2
`define ASC_PAR_ODD      2'h3
`define ASC_DIV_LO       9
`define ASC_DIV_HI       15
`define ASC_DIV_RESET    7'h02
`define ASC_PS_MAX       4'hB
`define ASC_ST_BFF       0
`define ASC_ST_TXBUSY    1
`define ASC_ST_RXVALID   2
`define ASC_ST_FEF       3
`define ASC_ST_PEF       4
`define ASC_ST_OVF       5
`define ASC_DATA_BITS    4'h8
`define ASC_HTRANS_NONSEQ 2'h2
`endif

// ---- hw/asc_fifo2.v ----
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/100ps
`default_nettype none
module asc_fifo2
(
  input  wire       clk,       // System clock.
  input  wire       rstn,      // Synchronous reset, active low.
  input  wire       in_valid,  // Word offered.
  output wire       in_ready,  // Room for a word.
  input  wire [7:0] in_data,   // Word in.
  output wire       out_valid, // Word available.
  input  wire       out_ready, // Consumer takes the word.
  output wire [7:0] out_data   // Oldest word.
);
  reg [7:0] mem_q [0:1];
  reg       wr_q;
  reg       rd_q;
  reg [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];

  // Pointers and count; a push and a pop together leave the count alone.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end

  // Storage needs no reset; empty entries are never shown as valid.
  always @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
endmodule // asc_fifo2
`default_nettype wire

// ---- hw/asc_top.v ----
// Asynchronous serial channel pair: even channel transmits, odd receives.
// Assumes an AHB-Lite master on the same clock and a UART partner on the pins.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`include "asc_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module asc_top
(
  input  wire        clk,             // System clock, 40 MHz.
  input  wire        rstn,            // Synchronous reset, active low.
  input  wire        hsel,            // AHB slave select.
  input  wire [31:0] haddr,           // AHB address.
  input  wire [1:0]  htrans,          // AHB transfer type.
  input  wire        hwrite,          // AHB write.
  input  wire [2:0]  hsize,           // AHB size, word only.
  input  wire        hready,          // AHB bus ready.
  input  wire [31:0] hwdata,          // AHB write data.
  output reg  [31:0] hrdata,          // AHB read data.
  output wire        hreadyout,       // Always ready.
  output wire        hresp,           // Always OKAY.
  input  wire        serial_rx_pin,   // Receive line from partner.
  output reg         serial_tx_pin,   // Transmit line to partner.
  output reg         tx_irq,          // Transmit interrupt pulse.
  output reg         rx_complete_irq, // Receive transfer-end pulse.
  output reg         rx_error_irq     // Receive error pulse.
);
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_DATA  = 5'h04;
  localparam [4:0] S_PAR   = 5'h08;
  localparam [4:0] S_STOP  = 5'h10;
  reg        pen_q;
  reg  [3:0] ps_q;
  reg  [7:0] txmode_q;
  reg  [7:0] rxmode_q;
  reg  [2:0] fmt_q;
  reg  [6:0] txdiv_q;
  reg  [6:0] rxdiv_q;
  reg        fef_q, pef_q, ovf_q;
  reg  [7:0] txbuf_q;
  reg        bff_q;
  reg  [11:0] pre_q;
  // Bus address phase capture.
  reg        wr_pend_q;
  reg  [5:0] wr_addr_q;
  wire       aphase = hsel && hready && (htrans == `ASC_HTRANS_NONSEQ);
  wire [5:0] a_off  = {haddr[5:2], 2'b00};
  wire       wr_en  = wr_pend_q;
  wire       inv    = fmt_q[`ASC_FMT_INV];
  wire [1:0] par    = fmt_q[`ASC_FMT_PAR_HI:`ASC_FMT_PAR_LO];
  wire       rd_pop = aphase && !hwrite && (a_off == `ASC_OFF_RXSDR);
  wire       tx_wr  = wr_en && (wr_addr_q == `ASC_OFF_TXSDR) && pen_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // Address phase is latched; the write lands with hwdata in the data phase.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 6'h00;
    end
    else
    begin
      wr_pend_q <= aphase && hwrite && (hsize == 3'h2);
      wr_addr_q <= a_off;
    end
  end
  // Configuration registers; only enable is writable while the unit is off.
  // The prescaler is not guarded against an early write after enable.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      pen_q    <= 1'b0;
      ps_q     <= 4'h0;
      txmode_q <= 8'h00;
      rxmode_q <= 8'h00;
      fmt_q    <= 3'h0;
      txdiv_q  <= `ASC_DIV_RESET;
      rxdiv_q  <= `ASC_DIV_RESET;
    end
    else if (wr_en)
    begin
      if (wr_addr_q == `ASC_OFF_PEN)
        pen_q <= hwdata[0];
      if (pen_q)
      begin
        case (wr_addr_q)
          `ASC_OFF_PRESCALE: ps_q <= (hwdata[3:0] > `ASC_PS_MAX) ? `ASC_PS_MAX : hwdata[3:0];
          `ASC_OFF_TXMODE:   txmode_q <= hwdata[7:0];
          `ASC_OFF_RXMODE:   rxmode_q <= hwdata[7:0];
          `ASC_OFF_FORMAT:   fmt_q <= hwdata[2:0];
          `ASC_OFF_TXSDR:    txdiv_q <= hwdata[`ASC_DIV_HI:`ASC_DIV_LO];
          `ASC_OFF_RXSDR:    rxdiv_q <= hwdata[`ASC_DIV_HI:`ASC_DIV_LO];
          default:           ps_q <= ps_q;
        endcase
      end
    end
  end
  // Shared prescaler: a tick every 2^ps system clocks gives the operation clock.
  wire [11:0] ps_mask = ~(12'hFFF << ps_q);
  wire        mck_tick = pen_q && ((pre_q & ps_mask) == ps_mask);
  always @(posedge clk)
  begin
    if (!rstn || !pen_q)
      pre_q <= 12'h000;
    else
      pre_q <= pre_q + 12'h001;
  end
  // Transmit channel, the even one of the pair.
  reg  [4:0] tx_st_q;
  reg  [7:0] tx_sh_q;
  reg  [3:0] tx_cnt_q;
  reg        tx_par_q;
  wire       tx_en    = pen_q && txmode_q[`ASC_MODE_EN];
  wire       tx_md    = txmode_q[`ASC_MODE_MD];
  wire       tx_idle  = (tx_st_q == S_IDLE);
  wire       tx_bit_tick;
  wire       tx_load  = tx_en && bff_q && (tx_idle || (tx_st_q == S_STOP && tx_bit_tick));
  asc_baud u_tx_baud
  (
    .clk      (clk),
    .rstn     (rstn),
    .restart  (tx_load || !tx_en),
    .mck_tick (mck_tick),
    .div      (txdiv_q),
    .half_tick(),
    .bit_tick (tx_bit_tick)
  );
  // Buffer full flag: a write always wins over the move into the shifter.
  always @(posedge clk)
  begin
    if (!rstn || !pen_q)
    begin
      bff_q   <= 1'b0;
      txbuf_q <= 8'h00;
    end
    else if (tx_wr)
    begin
      bff_q   <= 1'b1;
      txbuf_q <= hwdata[7:0];
    end
    else if (tx_load)
      bff_q <= 1'b0;
  end
  // Frame sequencer: start, eight data bits LSB first, optional parity, one stop.
  always @(posedge clk)
  begin
    if (!rstn || !tx_en)
    begin
      tx_st_q  <= S_IDLE;
      tx_sh_q  <= 8'h00;
      tx_cnt_q <= 4'h0;
      tx_par_q <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_st_q  <= S_START;
      tx_sh_q  <= txbuf_q;
      tx_cnt_q <= 4'h0;
      tx_par_q <= (par == `ASC_PAR_EVEN) ? ^txbuf_q :
                  (par == `ASC_PAR_ODD) ? ~^txbuf_q : 1'b0;
    end
    else if (tx_bit_tick)
    begin
      case (tx_st_q)
        S_START: tx_st_q <= S_DATA;
        S_DATA:
        begin
          tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
          tx_cnt_q <= tx_cnt_q + 4'h1;
          if (tx_cnt_q == `ASC_DATA_BITS - 4'h1)
            tx_st_q <= (par == `ASC_PAR_NONE) ? S_STOP : S_PAR;
        end
        S_PAR:   tx_st_q <= S_STOP;
        S_STOP:  tx_st_q <= S_IDLE;
        default: tx_st_q <= S_IDLE;
      endcase
    end
  end
  // Line level; the idle level follows the polarity bit.
  reg tx_bit;
  always @*
  begin
    case (tx_st_q)
      S_START: tx_bit = 1'b0;
      S_DATA:  tx_bit = tx_sh_q[0];
      S_PAR:   tx_bit = tx_par_q;
      default: tx_bit = 1'b1;
    endcase
  end
  always @(posedge clk)
  begin
    if (!rstn)
      serial_tx_pin <= 1'b1;
    else
      serial_tx_pin <= tx_bit ^ inv;
  end
  // Transmit interrupt: the source bit is read live, so late changes count.
  always @(posedge clk)
  begin
    if (!rstn)
      tx_irq <= 1'b0;
    else if (tx_md)
      tx_irq <= tx_load;
    else
      tx_irq <= tx_en && (tx_st_q == S_STOP) && tx_bit_tick;
  end
  // Receive channel, the odd one of the pair.
  reg        rx_s1_q, rx_s2_q, rx_s3_q;
  reg  [4:0] rx_st_q;
  reg  [7:0] rx_sh_q;
  reg  [3:0] rx_cnt_q;
  reg        rx_pbit_q;
  wire       rx_en   = pen_q && rxmode_q[`ASC_MODE_EN];
  wire       rx_line = rx_s2_q ^ inv;
  wire       rx_prev = rx_s3_q ^ inv;
  wire       rx_fall = rx_prev && !rx_line;
  wire       rx_go   = (rx_st_q == S_IDLE) && rx_fall;
  wire       rx_half;
  wire       fifo_ready;
  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire       rx_done = (rx_st_q == S_STOP) && rx_half;
  wire       par_exp = (par == `ASC_PAR_EVEN) ? ^rx_sh_q : ~^rx_sh_q;
  wire       par_bad = par[1] && (rx_pbit_q != par_exp);
  wire       frm_bad = !rx_line;
  // Two flops bring the asynchronous pin into the clock domain.
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= serial_rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end
  asc_baud u_rx_baud
  (
    .clk      (clk),
    .rstn     (rstn),
    .restart  (rx_go || !rx_en),
    .mck_tick (mck_tick),
    .div      (rxdiv_q),
    .half_tick(rx_half),
    .bit_tick ()
  );
  // Every bit is sampled at its centre; a start bit gone high is a glitch.
  always @(posedge clk)
  begin
    if (!rstn || !rx_en)
    begin
      rx_st_q   <= S_IDLE;
      rx_sh_q   <= 8'h00;
      rx_cnt_q  <= 4'h0;
      rx_pbit_q <= 1'b0;
    end
    else if (rx_go)
    begin
      rx_st_q  <= S_START;
      rx_cnt_q <= 4'h0;
    end
    else if (rx_half)
    begin
      case (rx_st_q)
        S_START: rx_st_q <= rx_line ? S_IDLE : S_DATA;
        S_DATA:
        begin
          rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == `ASC_DATA_BITS - 4'h1)
            rx_st_q <= (par == `ASC_PAR_NONE) ? S_STOP : S_PAR;
        end
        S_PAR:
        begin
          rx_pbit_q <= rx_line;
          rx_st_q   <= S_STOP;
        end
        S_STOP:  rx_st_q <= S_IDLE;
        default: rx_st_q <= S_IDLE;
      endcase
    end
  end
  // Received words wait here so a slow reader does not lose the next one.
  asc_fifo2 u_rx_fifo
  (
    .clk      (clk),
    .rstn     (rstn),
    .in_valid (rx_done),
    .in_ready (fifo_ready),
    .in_data  (rx_sh_q),
    .out_valid(fifo_valid),
    .out_ready(rd_pop),
    .out_data (fifo_data)
  );

  // Error flags: a new error wins over a clear written in the same cycle.
  // Receive interrupts share the process; the odd channel's source bit is ignored.
  wire clr_wr = wr_en && (wr_addr_q == `ASC_OFF_FLAGCLR);
  wire set_f  = rx_done && frm_bad;
  wire set_p  = rx_done && par_bad;
  wire set_o  = rx_done && !fifo_ready;
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      fef_q           <= 1'b0;
      pef_q           <= 1'b0;
      ovf_q           <= 1'b0;
      rx_complete_irq <= 1'b0;
      rx_error_irq    <= 1'b0;
    end
    else
    begin
      fef_q <= set_f || (fef_q && !(clr_wr && hwdata[`ASC_ST_FEF]));
      pef_q <= set_p || (pef_q && !(clr_wr && hwdata[`ASC_ST_PEF]));
      ovf_q <= set_o || (ovf_q && !(clr_wr && hwdata[`ASC_ST_OVF]));
      rx_complete_irq <= rx_done;
      rx_error_irq    <= set_f || set_p || set_o;
    end
  end

  // Read data are registered at the address phase; unmapped words read zero.
  always @(posedge clk)
  begin
    if (!rstn)
      hrdata <= 32'h00000000;
    else if (aphase && !hwrite)
    begin
      case (a_off)
        `ASC_OFF_PEN:      hrdata <= {31'h0, pen_q};
        `ASC_OFF_PRESCALE: hrdata <= {28'h0, ps_q};
        `ASC_OFF_TXMODE:   hrdata <= {24'h0, txmode_q};
        `ASC_OFF_RXMODE:   hrdata <= {24'h0, rxmode_q};
        `ASC_OFF_FORMAT:   hrdata <= {29'h0, fmt_q};
        `ASC_OFF_TXSDR:    hrdata <= {16'h0, txdiv_q, 1'b0, txbuf_q};
        `ASC_OFF_RXSDR:    hrdata <= {16'h0, rxdiv_q, 1'b0, fifo_valid ? fifo_data : 8'h00};
        `ASC_OFF_STATUS:   hrdata <= {26'h0, ovf_q, pef_q, fef_q, fifo_valid, !tx_idle, bff_q};
        default:           hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule // asc_top
`default_nettype wire

// ---- tb/asc_monitor.sv ----
// Timing checks on the pins and interrupts of the serial channel pair.
// Assumes a divisor of 2 or more; bound to the top module below.
`timescale 1ns/100ps
`default_nettype none
module asc_monitor
(
  input wire logic clk,             // System clock.
  input wire logic rstn,            // Reset, active low.
  input wire logic hreadyout,       // Bus ready.
  input wire logic hresp,           // Bus response.
  input wire logic serial_tx_pin,   // Transmit line.
  input wire logic tx_irq,          // Transmit pulse.
  input wire logic rx_complete_irq, // Receive done pulse.
  input wire logic rx_error_irq     // Receive error pulse.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // The bus never stalls and never errs.
  AST_READY: assert property (hreadyout) else $error("hreadyout low");
  AST_RESP: assert property (!hresp) else $error("hresp not okay");
  AST_TX_RESET: assert property ($rose(rstn) |-> serial_tx_pin)
    else $error("line not idle after reset");
  // A bit lasts at least six clocks, since the divisor is never below 2.
  AST_TX_BIT: assert property ($changed(serial_tx_pin) |=> $stable(serial_tx_pin)[*5])
    else $error("bit too short");
  AST_TX_GAP: assert property (tx_irq |=> !tx_irq [*5])
    else $error("transmit pulses too close");
  AST_RXC_GAP: assert property (rx_complete_irq |=> !rx_complete_irq [*8])
    else $error("receive pulses too close");
  // An error pulse always comes with the word it belongs to.
  AST_ERR_PAIR: assert property (rx_error_irq |-> rx_complete_irq)
    else $error("error pulse without word");
  AST_ERR_PULSE: assert property (rx_error_irq |=> !rx_error_irq)
    else $error("error pulse too long");
endmodule // asc_monitor
bind asc_top asc_monitor i_mon (.clk(clk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp),
  .serial_tx_pin(serial_tx_pin), .tx_irq(tx_irq), .rx_complete_irq(rx_complete_irq),
  .rx_error_irq(rx_error_irq));
`default_nettype wire

// ---- tb/asc_partner.sv ----
// Far-side serial device: sends frames to the block and captures its output.
// Assumes the bench sets polarity and parity here to match the block.
`timescale 1ns/100ps
`default_nettype none
module asc_partner
#(
  parameter int BIT_CLKS = 6 // Divisor 2 at prescaler 0.
)
(
  input  wire logic clk,     // Timing only; nothing shared on the line.
  input  wire logic tx_line, // From the block.
  output var  logic rx_line  // To the block.
);
  logic       inv = 1'b0; // Polarity.
  logic [1:0] par = 2'h0; // Parity mode.
  initial rx_line = 1'b1;
  // Start, data LSB first, optional parity, one stop, then idle level.
  task automatic send(input logic [7:0] d, input logic bp, input logic bs);
    logic [10:0] f;
    f = {~bs, (par[1] & (^d ^ par[0])) ^ bp, d, 1'b0};
    if (par == 2'h0)
      f = {1'b1, f[10], d, 1'b0};
    for (int i = 0; i < (par == 2'h0 ? 10 : 11); i++)
    begin
      @(posedge clk);
      rx_line <= f[i] ^ inv;
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= ~inv;
  endtask
  // Find a start bit, then sample each data bit and the stop bit at its centre; a parity bit is skipped.
  task automatic grab(output logic [7:0] d, output logic st);
    do @(posedge clk); while (tx_line !== inv);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk);
      d[i] = tx_line ^ inv;
    end
    repeat (par == 2'h0 ? BIT_CLKS : 2 * BIT_CLKS) @(posedge clk);
    st = tx_line ^ inv;
  endtask
endmodule // asc_partner
`default_nettype wire

// ---- tb/tb_async_serial_channel_pair.sv ----
// Bench for the serial channel pair: registers over AHB-Lite, frames on the pins.
// Assumes prescaler 0 and divisor 2, so a bit lasts six clocks.
`include "asc_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_async_serial_channel_pair;
  logic        clk, rstn, hsel, hwrite;   // Clock, reset, bus controls.
  logic [31:0] haddr, hwdata;             // Bus address and write data.
  logic [1:0]  htrans;                    // Transfer type.
  wire  [31:0] hrdata;                    // Read data.
  wire         hreadyout, hresp;          // Slave answer.
  wire         rx_pin, tx_pin;            // Serial lines.
  wire         tx_irq, rxc_irq, rxe_irq;  // Interrupt pulses.
  int          fail_count = 0, checked = 0, cycles = 0;
  int          n_tx = 0, n_rx = 0, n_err = 0;
  logic [31:0] rd;
  logic [7:0]  b;
  logic        st;
  asc_top i_dut
  (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin),
    .tx_irq(tx_irq), .rx_complete_irq(rxc_irq), .rx_error_irq(rxe_irq)
  );
  asc_partner i_partner (.clk(clk), .tx_line(tx_pin), .rx_line(rx_pin));
  // 40 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Count pulses; a run far past its expected length is cut short.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    n_tx <= n_tx + int'(tx_irq === 1'b1);
    n_rx <= n_rx + int'(rxc_irq === 1'b1);
    n_err <= n_err + int'(rxe_irq === 1'b1);
    if (cycles == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One single transfer; read data is taken at the end of the data phase.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {26'h0, a};
    htrans <= `ASC_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Receiver is held off while polarity flips, so the swing is no start bit.
  task automatic set_fmt(input logic inv, input logic [1:0] par);
    bus(1'b1, `ASC_OFF_RXMODE, 32'h0);
    bus(1'b1, `ASC_OFF_FORMAT, {29'h0, par, inv});
    i_partner.inv = inv;
    i_partner.par = par;
    i_partner.rx_line <= ~inv;
    repeat (8) @(posedge clk);
    bus(1'b1, `ASC_OFF_RXMODE, 32'h80);
  endtask
  task automatic t_reset;
    bus(1'b0, `ASC_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `ASC_OFF_RXSDR, 32'h0);
    chk(rd, 32'h400);
    bus(1'b0, 6'h3C, 32'h0);
    chk(rd, 32'h0);
    chk(tx_pin, 1'b1);
  endtask
  task automatic t_tx(input logic [7:0] d, input logic inv);
    int n0;
    set_fmt(inv, 2'h0);
    chk({31'h0, tx_pin}, {31'h0, ~inv});
    n0 = n_tx;
    fork
      bus(1'b1, `ASC_OFF_TXSDR, {16'h0, 7'h02, 1'b0, d});
      i_partner.grab(b, st);
    join
    repeat (8) @(posedge clk);
    chk(b, d);
    chk(st, 1'b1);
    chk(n_tx - n0, 1);
  endtask
  task automatic rx_one(input logic [7:0] d, input logic bp, input logic bs, input logic e,
                        input logic [31:0] s);
    int r0;
    int e0;
    r0 = n_rx;
    e0 = n_err;
    i_partner.send(d, bp, bs);
    for (int k = 0; k < 40 && n_rx == r0; k++)
      @(posedge clk);
    chk(n_rx - r0, 1);
    chk(n_err - e0, e);
    bus(1'b0, `ASC_OFF_RXSDR, 32'h0);
    chk(rd, {16'h0, 7'h02, 1'b0, d});
    bus(1'b0, `ASC_OFF_STATUS, 32'h0);
    chk(rd, s);
  endtask
  // Every parity mode; a wrong bit under zero parity goes unflagged.
  task automatic t_rx_modes;
    for (int p = 0; p < 4; p++)
    begin
      set_fmt(1'b0, p[1:0]);
      rx_one(8'hA5 + p[7:0], p == 1, 1'b0, 1'b0, 32'h0);
    end
    set_fmt(1'b1, 2'h3);
    rx_one(8'h3C, 1'b0, 1'b0, 1'b0, 32'h0);
  endtask
  task automatic t_errors;
    set_fmt(1'b0, 2'h2);
    rx_one(8'h81, 1'b1, 1'b0, 1'b1, 32'h10);
    rx_one(8'h42, 1'b0, 1'b0, 1'b0, 32'h10);
    rx_one(8'h24, 1'b0, 1'b1, 1'b1, 32'h18);
    bus(1'b1, `ASC_OFF_FLAGCLR, 32'h38);
    bus(1'b0, `ASC_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Software stalls: the third word finds the buffer full.
  task automatic t_overrun;
    set_fmt(1'b0, 2'h0);
    for (int i = 0; i < 3; i++)
      i_partner.send(8'h10 + i[7:0], 1'b0, 1'b0);
    repeat (6) @(posedge clk);
    bus(1'b0, `ASC_OFF_STATUS, 32'h0);
    chk(rd, 32'h24);
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b0, `ASC_OFF_RXSDR, 32'h0);
      chk(rd, {16'h0, 7'h02, 1'b0, 8'h10 + i[7:0]});
    end
    bus(1'b1, `ASC_OFF_FLAGCLR, 32'h20);
  endtask
  // Continuous mode: a write while full replaces the pending word.
  task automatic t_continuous;
    int n0;
    bus(1'b1, `ASC_OFF_TXMODE, 32'h81);
    n0 = n_tx;
    fork
      begin
        bus(1'b1, `ASC_OFF_TXSDR, 32'h411);
        bus(1'b1, `ASC_OFF_TXSDR, 32'h412);
        bus(1'b0, `ASC_OFF_STATUS, 32'h0);
        chk(rd[0], 1'b1);
        bus(1'b1, `ASC_OFF_TXSDR, 32'h413);
      end
      i_partner.grab(b, st);
    join
    chk(b, 8'h11);
    fork
      begin
        repeat (6) @(posedge clk);
        bus(1'b1, `ASC_OFF_TXMODE, 32'h80);
      end
      i_partner.grab(b, st);
    join
    repeat (8) @(posedge clk);
    chk(b, 8'h13);
    chk(n_tx - n0, 3);
  endtask
  // Reset for eight clocks, then each scenario in turn.
  initial
  begin
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    bus(1'b1, `ASC_OFF_PEN, 32'h1);
    repeat (4) @(posedge clk);
    bus(1'b1, `ASC_OFF_PRESCALE, 32'h0);
    bus(1'b1, `ASC_OFF_TXMODE, 32'h80);
    t_tx(8'h5A, 1'b0);
    t_tx(8'hC3, 1'b1);
    t_rx_modes();
    t_errors();
    t_overrun();
    t_continuous();
    wrap_up();
  end
endmodule // tb_async_serial_channel_pair
`default_nettype wire
